// ---- bench/lcr_top_assertions.sv ----
// lcr_checker: concurrent checks on the lane register slave, port 0 lane.
// assumes port 0 sits at byte address 0x130B8 and clk_en stays high.
module lcr_checker #(
   parameter int NPORT = 4
)
(
   // clock and bus
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic clk_en,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   // port context and lane controls
   input wire logic [NPORT-1:0] init_bypass,
   input wire logic [NPORT-1:0] rx_pll_state,
   input wire logic [NPORT-1:0] tx_emphasis_recalc_trigger,
   input wire logic [NPORT*3-1:0] tx_power,
   input wire logic [NPORT*4-1:0] tx_boost,
   input wire logic [NPORT-1:0] rx_pll_power,
   input wire logic [NPORT-1:0] rx_output_enable,
   input wire logic [NPORT-1:0] dpll_freq_reset,
   input wire logic [NPORT*3-1:0] rx_equalizer_level,
   input wire logic [NPORT*2-1:0] signal_loss_detect_ctl
);
   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic wr0;
   assign wr0 = hsel && hready && htrans[1] && hwrite && clk_en && haddr == 32'h000130B8;
   a_recalc_one: assert property (tx_emphasis_recalc_trigger[0] |=> !tx_emphasis_recalc_trigger[0])
      else $error("recalc pulse too long");
   a_recalc_cause: assert property (tx_emphasis_recalc_trigger[0] |-> $past(wr0, 3) && $past(hwdata[1], 2))
      else $error("recalc pulse without write");
   a_dpll_one: assert property (dpll_freq_reset[0] |=> !dpll_freq_reset[0])
      else $error("dpll pulse too long");
   a_dpll_cause: assert property (dpll_freq_reset[0] |-> $past(wr0, 3) && $past(hwdata[18], 2))
      else $error("dpll pulse without write");
   // sync delay of the pll state is allowed for by six cycles
   a_rxen_lock: assert property ((!rx_pll_state[0]) [*6] |-> !rx_output_enable[0])
      else $error("receive enable without pll state");
   a_rxen_power: assert property (rx_output_enable[0] |-> rx_pll_power[0])
      else $error("receive enable without pll power");
   a_guard_hold: assert property ((!init_bypass[0]) [*6] |=> $stable({tx_power[2:0], rx_pll_power[0]}))
      else $error("guarded field changed");
   a_boost_write: assert property (wr0 ##2 1 |=> tx_boost[3:0] == $past(hwdata[15:12], 2))
      else $error("boost not written");
   a_eq_los_write: assert property (wr0 ##2 1 |=> {rx_equalizer_level[2:0], signal_loss_detect_ctl[1:0]} == $past({hwdata[23:21], hwdata[29:28]}, 2))
      else $error("equaliser or loss field not written");
   cover property (tx_emphasis_recalc_trigger[0]);
   cover property (dpll_freq_reset[0]);
   cover property ($rose(rx_output_enable[0]));
endmodule : lcr_checker

bind lcr_top lcr_checker #(.NPORT(NPORT)) lcr_checker_inst (.hclk, .hresetn, .clk_en, .hsel,
   .haddr, .htrans, .hwrite, .hwdata, .hready, .init_bypass, .rx_pll_state,
   .tx_emphasis_recalc_trigger, .tx_power, .tx_boost, .rx_pll_power, .rx_output_enable,
   .dpll_freq_reset, .rx_equalizer_level, .signal_loss_detect_ctl);

// ---- bench/tb.sv ----
// tb: AHB-Lite register tests of the lane 2 configuration slave.
// assumes a zero-wait slave whose hreadyout feeds hready.
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import lcr_pkg::*;
   // ------------------------------------------------------------------
   // signals
   // ------------------------------------------------------------------
   // half-rate reset is undefined and taken as 0
   localparam logic [31:0] rst_word = 32'hC8A7C610;
   localparam logic [31:0] w_a = 32'hB85C31AC;
   localparam logic [31:0] w_b = 32'hB85F31AC;
   localparam logic [31:0] w_c = w_b & ~32'h00040002;
   localparam logic [31:0] w_d = w_b | 32'h00040002;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, r;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [3:0] init_bypass, rx_pll_state, half_rate, tx_emphasis_recalc_trigger, rx_pll_power;
   logic [3:0] rx_output_enable, dpll_freq_reset, tx_domain_clock_power, word_align_en;
   logic [11:0] tx_power, rx_equalizer_level, rx_dpll_select;
   logic [15:0] tx_boost;
   logic [7:0] signal_loss_detect_ctl;
   int n_fail = 0;
   int checks_done = 0;
   int n_rc = 0;
   int n_dr = 0;
   lcr_top #(.NPORT(4)) lcr_top_inst (.hclk, .hresetn, .clk_en(1'b1), .hsel, .haddr, .htrans,
      .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .init_bypass,
      .rx_pll_state, .half_rate, .tx_emphasis_recalc_trigger, .tx_power, .tx_boost,
      .rx_pll_power, .rx_output_enable, .dpll_freq_reset, .rx_equalizer_level,
      .rx_dpll_select, .tx_domain_clock_power, .signal_loss_detect_ctl, .word_align_en);
   // ------------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------------
   function automatic logic [31:0] adr(input int p);
      return 32'h000130B8 + 32'(p) * 32'h200;
   endfunction : adr
   task automatic test_done;
      if (n_fail == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : test_done
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask : bus
   task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(r, exp);
      chk(32'(hresp), 32'h0);
   endtask : rdchk
   task automatic chk_out(input int p, input logic [31:0] w);
      chk(32'({word_align_en[p], signal_loss_detect_ctl[p*2+:2], tx_domain_clock_power[p],
         rx_dpll_select[p*3+:3], rx_equalizer_level[p*3+:3], rx_pll_power[p],
         tx_boost[p*4+:4], tx_power[p*3+:3], half_rate[p]}), 32'({w[30:21], w[16:9], w[0]}));
      chk(32'(rx_output_enable[p]), 32'(w[17] & w[16] & rx_pll_state[p]));
   endtask : chk_out
   // ------------------------------------------------------------------
   // stimulus
   // ------------------------------------------------------------------
   always @(posedge hclk) begin
      if (tx_emphasis_recalc_trigger[0] === 1'b1) n_rc++;
      if (dpll_freq_reset[0] === 1'b1) n_dr++;
   end
   initial begin
      hclk = 1'b0;
      forever #10 hclk = ~hclk;
   end
   initial begin
      #50us;
      n_fail++;
      test_done();
   end
   initial begin
      {hresetn, hsel, hwrite, htrans, haddr, hwdata, init_bypass, rx_pll_state} = '0;
      hsize = 3'h2;
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      for (int p = 0; p < 4; p++) begin
         rdchk(adr(p), rst_word);
         chk_out(p, rst_word);
      end
      bus(1'b1, 32'h000130BC, 32'hFFFFFFFF);
      rdchk(32'h000130BC, 32'h0);
      for (int p = 0; p < 4; p++) begin
         bus(1'b1, adr(p), w_a);
         rdchk(adr(p), w_a & ~LCR_MASK_GUARDED & ~LCR_MASK_RO | rst_word & LCR_MASK_GUARDED);
         chk_out(p, w_a & ~LCR_MASK_GUARDED | rst_word & LCR_MASK_GUARDED);
      end
      init_bypass <= 4'hF;
      rx_pll_state <= 4'hF;
      repeat (8) @(posedge hclk);
      for (int p = 0; p < 4; p++) begin
         bus(1'b1, adr(p), w_b);
         rdchk(adr(p), w_b & ~LCR_MASK_RO);
         chk_out(p, w_b);
      end
      rx_pll_state <= 4'hE;
      repeat (8) @(posedge hclk);
      bus(1'b1, adr(0), w_c);
      bus(1'b1, adr(0), w_d);
      repeat (2) @(posedge hclk);
      rdchk(adr(0), w_d & ~LCR_MASK_RO);
      chk_out(0, w_d & ~32'h00020000);
      bus(1'b1, adr(0), w_d & ~32'h00020000);
      bus(1'b1, adr(0), w_d);
      rdchk(adr(0), w_d & ~LCR_MASK_RO & ~32'h00020000);
      chk(32'(n_rc), 32'h1);
      chk(32'(n_dr), 32'h1);
      test_done();
   end
endmodule : tb

// ---- verilog/lcr_lane_reg.sv ----
// lcr_lane_reg: one lane 2 configuration word with its edge triggers.
// assumes a one-cycle write strobe from the bus slave in the same clock.
module lcr_lane_reg
   import lcr_pkg::*;
(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic clk_en,
   // write side
   input wire logic wr_stb,
   input wire logic [31:0] wr_data,
   input wire logic init_bypass,
   input wire logic rx_pll_state,
   // state
   output logic [31:0] cfg,
   output logic tx_recalc_pulse,
   output logic dpll_rst_pulse
);

   // ------------------------------------------------------------------
   // write merge
   // ------------------------------------------------------------------
   wire logic [31:0] wr_mask;
   wire logic [31:0] merged;
   wire logic rx_en_allowed;
   logic [31:0] next_cfg;

   assign wr_mask = ~LCR_MASK_RO & (init_bypass ? 32'hFFFFFFFF : ~LCR_MASK_GUARDED);
   assign merged = (wr_data & wr_mask) | (cfg & ~wr_mask);
   assign rx_en_allowed = merged[LCR_B_RX_PLL_PWR] & rx_pll_state;

   always_comb begin
      next_cfg = merged;
      // receive output may only rise while the pll is powered and locked
      if (!cfg[LCR_B_RX_OUT_EN] && !rx_en_allowed) begin
         next_cfg[LCR_B_RX_OUT_EN] = 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cfg <= LCR_RESET;
         tx_recalc_pulse <= 1'b0;
         dpll_rst_pulse <= 1'b0;
      end else if (clk_en) begin
         tx_recalc_pulse <= wr_stb & ~cfg[LCR_B_TX_RECALC] & wr_data[LCR_B_TX_RECALC];
         dpll_rst_pulse <= wr_stb & ~cfg[LCR_B_DPLL_RST] & wr_data[LCR_B_DPLL_RST];
         if (wr_stb) begin
            cfg <= next_cfg;
         end
      end
   end

endmodule : lcr_lane_reg

// ---- verilog/lcr_pkg.sv ----
// lcr_pkg: offsets, field positions, reset values and codes for the lane 2
// serdes configuration registers of four ports.
// assumes a 32-bit AHB-Lite register bus, one aligned word per register.
package lcr_pkg;

   // ------------------------------------------------------------------
   // geometry
   // ------------------------------------------------------------------
   localparam int LCR_NPORT = 4;
   localparam int LCR_AW = 20;
   localparam logic [19:0] LCR_OFF_PORT0 = 20'h130B8;
   localparam logic [19:0] LCR_OFF_PORT2 = 20'h132B8;
   localparam logic [19:0] LCR_OFF_PORT4 = 20'h134B8;
   localparam logic [19:0] LCR_OFF_PORT6 = 20'h136B8;
   localparam logic [19:0] LCR_PORT_STRIDE = 20'h00200;

   // ------------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------------
   localparam int LCR_B_HALF_RATE = 0;
   localparam int LCR_B_TX_RECALC = 1;
   localparam int LCR_B_UNUSED_LO = 2;
   localparam int LCR_B_RSVD8 = 8;
   localparam int LCR_B_TX_PWR_LO = 9;
   localparam int LCR_B_TX_BOOST_LO = 12;
   localparam int LCR_B_RX_PLL_PWR = 16;
   localparam int LCR_B_RX_OUT_EN = 17;
   localparam int LCR_B_DPLL_RST = 18;
   localparam int LCR_B_RSVD19_LO = 19;
   localparam int LCR_B_RX_EQ_LO = 21;
   localparam int LCR_B_DPLL_SEL_LO = 24;
   localparam int LCR_B_TX_CLK_PWR = 27;
   localparam int LCR_B_LOS_LO = 28;
   localparam int LCR_B_ALIGN_EN = 30;
   localparam int LCR_B_RSVD31 = 31;

   // ------------------------------------------------------------------
   // reset value and masks
   // ------------------------------------------------------------------
   // half-rate bit has no defined reset; it is taken as 0 here
   localparam logic [31:0] LCR_RESET = 32'hC8A7C610;
   // bits that the gating of the init-bypass bit protects
   localparam logic [31:0] LCR_MASK_GUARDED = 32'h00030E00;
   // bit 8 reads zero and takes no writes
   localparam logic [31:0] LCR_MASK_RO = 32'h00000100;

   // ------------------------------------------------------------------
   // codes
   // ------------------------------------------------------------------
   localparam logic [2:0] LCR_TXPWR_OFF = 3'h0;
   localparam logic [2:0] LCR_TXPWR_ON = 3'h3;
   localparam logic [1:0] LCR_LOS_OFF = 2'h0;
   localparam logic [1:0] LCR_LOS_HEAVY = 2'h3;

   typedef enum logic [1:0] {
      LCR_ST_IDLE = 2'b01,
      LCR_ST_DATA = 2'b10
   } lcr_state_e;

endpackage : lcr_pkg

// ---- verilog/lcr_top.sv ----
// lcr_top: AHB-Lite slave holding the lane 2 serdes configuration word of
// four ports, with the lane controls driven out per port.
// assumes one AHB-Lite master; the analog lane and global register are outside.
//
// Implementation choice: register access over AHB-Lite.
module lcr_top
   import lcr_pkg::*;
#(
   parameter int NPORT = lcr_pkg::LCR_NPORT
)
(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic clk_en,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // port context
   input wire logic [NPORT-1:0] init_bypass,
   input wire logic [NPORT-1:0] rx_pll_state,
   // lane controls, one per port
   output logic [NPORT-1:0] half_rate,
   output logic [NPORT-1:0] tx_emphasis_recalc_trigger,
   output logic [NPORT*3-1:0] tx_power,
   output logic [NPORT*4-1:0] tx_boost,
   output logic [NPORT-1:0] rx_pll_power,
   output logic [NPORT-1:0] rx_output_enable,
   output logic [NPORT-1:0] dpll_freq_reset,
   output logic [NPORT*3-1:0] rx_equalizer_level,
   output logic [NPORT*3-1:0] rx_dpll_select,
   output logic [NPORT-1:0] tx_domain_clock_power,
   output logic [NPORT*2-1:0] signal_loss_detect_ctl,
   output logic [NPORT-1:0] word_align_en
);

   // the address decode maps exactly four ports
   if (NPORT != LCR_NPORT) begin : g_bad_nport
      $error("lcr_top: NPORT must equal the four mapped ports");
   end

   // ------------------------------------------------------------------
   // pin synchronisers for the port context (outside this clock)
   // ------------------------------------------------------------------
   logic [NPORT-1:0] byp_s1;
   logic [NPORT-1:0] byp_s2;
   logic [NPORT-1:0] byp_s3;
   logic [NPORT-1:0] byp_q;
   logic [NPORT-1:0] pll_s1;
   logic [NPORT-1:0] pll_s2;
   logic [NPORT-1:0] pll_s3;
   logic [NPORT-1:0] pll_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         byp_s1 <= '0;
         byp_s2 <= '0;
         byp_s3 <= '0;
         pll_s1 <= '0;
         pll_s2 <= '0;
         pll_s3 <= '0;
      end else if (clk_en) begin
         byp_s1 <= init_bypass;
         byp_s2 <= byp_s1;
         byp_s3 <= byp_s2;
         pll_s1 <= rx_pll_state;
         pll_s2 <= pll_s1;
         pll_s3 <= pll_s2;
      end
   end

   // a change only counts once stages two and three agree
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         byp_q <= '0;
         pll_q <= '0;
      end else if (clk_en) begin
         byp_q <= (byp_s2 & byp_s3) | (byp_q & (byp_s2 | byp_s3));
         pll_q <= (pll_s2 & pll_s3) | (pll_q & (pll_s2 | pll_s3));
      end
   end

   // ------------------------------------------------------------------
   // bus address phase
   // ------------------------------------------------------------------
   wire logic addr_valid;
   wire logic [LCR_AW-1:0] rel_addr;
   wire logic [1:0] port_idx;
   wire logic addr_hit;

   assign addr_valid = hsel & hready & htrans[1];
   assign rel_addr = haddr[LCR_AW-1:0] - LCR_OFF_PORT0;
   assign port_idx = rel_addr[10:9];
   // stride of 0x200 between the four ports; upper address bits must be clear
   assign addr_hit = (haddr[31:LCR_AW] == 12'h000)
                   && (haddr[LCR_AW-1:0] >= LCR_OFF_PORT0)
                   && (haddr[LCR_AW-1:0] <= LCR_OFF_PORT6)
                   && (rel_addr[8:0] == 9'h000);

   // ------------------------------------------------------------------
   // data phase: always zero wait states, always OKAY
   // ------------------------------------------------------------------
   lcr_state_e state;
   logic dp_write;
   logic dp_hit;
   logic [1:0] dp_port;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= LCR_ST_IDLE;
         dp_write <= 1'b0;
         dp_hit <= 1'b0;
         dp_port <= 2'h0;
      end else if (clk_en) begin
         case (state)
            LCR_ST_IDLE, LCR_ST_DATA: begin
               state <= addr_valid ? LCR_ST_DATA : LCR_ST_IDLE;
               dp_write <= addr_valid & hwrite;
               dp_hit <= addr_valid & addr_hit;
               dp_port <= port_idx;
            end
            default: begin
               state <= LCR_ST_IDLE;
               dp_write <= 1'b0;
               dp_hit <= 1'b0;
               dp_port <= 2'h0;
            end
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // per port registers
   // ------------------------------------------------------------------
   wire logic [31:0] cfg [NPORT];
   wire logic [NPORT-1:0] recalc_p;
   wire logic [NPORT-1:0] dpll_p;
   wire logic rd_stb;

   assign rd_stb = addr_valid & ~hwrite & addr_hit;

   genvar g;
   generate
      for (g = 0; g < NPORT; g++) begin : g_port
         wire logic wr_stb_g;
         assign wr_stb_g = (state == LCR_ST_DATA) & dp_write & dp_hit
                         & (dp_port == 2'(g));

         lcr_lane_reg u_lane (
            .hclk(hclk),
            .hresetn(hresetn),
            .clk_en(clk_en),
            .wr_stb(wr_stb_g),
            .wr_data(hwdata),
            .init_bypass(byp_q[g]),
            .rx_pll_state(pll_q[g]),
            .cfg(cfg[g]),
            .tx_recalc_pulse(recalc_p[g]),
            .dpll_rst_pulse(dpll_p[g])
         );

         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               half_rate[g] <= LCR_RESET[LCR_B_HALF_RATE];
               tx_power[g*3 +: 3] <= LCR_RESET[LCR_B_TX_PWR_LO +: 3];
               tx_boost[g*4 +: 4] <= LCR_RESET[LCR_B_TX_BOOST_LO +: 4];
               rx_pll_power[g] <= LCR_RESET[LCR_B_RX_PLL_PWR];
               rx_output_enable[g] <= 1'b0;
               rx_equalizer_level[g*3 +: 3] <= LCR_RESET[LCR_B_RX_EQ_LO +: 3];
               rx_dpll_select[g*3 +: 3] <= LCR_RESET[LCR_B_DPLL_SEL_LO +: 3];
               tx_domain_clock_power[g] <= LCR_RESET[LCR_B_TX_CLK_PWR];
               signal_loss_detect_ctl[g*2 +: 2] <= LCR_RESET[LCR_B_LOS_LO +: 2];
               word_align_en[g] <= LCR_RESET[LCR_B_ALIGN_EN];
               tx_emphasis_recalc_trigger[g] <= 1'b0;
               dpll_freq_reset[g] <= 1'b0;
            end else if (clk_en) begin
               half_rate[g] <= cfg[g][LCR_B_HALF_RATE];
               tx_power[g*3 +: 3] <= cfg[g][LCR_B_TX_PWR_LO +: 3];
               tx_boost[g*4 +: 4] <= cfg[g][LCR_B_TX_BOOST_LO +: 4];
               rx_pll_power[g] <= cfg[g][LCR_B_RX_PLL_PWR];
               // outputs stay off while the pll is down, whatever the bit holds
               rx_output_enable[g] <= cfg[g][LCR_B_RX_OUT_EN]
                                    & cfg[g][LCR_B_RX_PLL_PWR] & pll_q[g];
               rx_equalizer_level[g*3 +: 3] <= cfg[g][LCR_B_RX_EQ_LO +: 3];
               rx_dpll_select[g*3 +: 3] <= cfg[g][LCR_B_DPLL_SEL_LO +: 3];
               tx_domain_clock_power[g] <= cfg[g][LCR_B_TX_CLK_PWR];
               signal_loss_detect_ctl[g*2 +: 2] <= cfg[g][LCR_B_LOS_LO +: 2];
               word_align_en[g] <= cfg[g][LCR_B_ALIGN_EN];
               tx_emphasis_recalc_trigger[g] <= recalc_p[g];
               dpll_freq_reset[g] <= dpll_p[g];
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------------
   // read data, registered so it stands through the data phase
   // ------------------------------------------------------------------
   wire logic [31:0] rd_word;
   assign rd_word = cfg[port_idx] & ~LCR_MASK_RO;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h00000000;
      end else if (clk_en) begin
         if (rd_stb) begin
            hrdata <= rd_word;
         end else if (addr_valid) begin
            hrdata <= 32'h00000000;
         end
      end
   end

endmodule : lcr_top
